// ==== core/rsa_alu.sv ====
`timescale 1ns/1ns
module rsa_alu
  import rsa_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // request
  input  wire logic        START,
  input  rsa_op_t          OP,
  input  rsa_instr_t       INSTR,
  // operands
  input  wire logic [15:0] DEST_VAL,
  input  wire logic [15:0] SRC_VAL,
  input  wire logic [15:0] MEM_VAL,
  input  wire logic [15:0] PTR_VAL,
  input  wire logic [7:0]  SEG_VAL,
  input  wire logic        FLAG_C,
  input  wire logic        FLAG_N,
  // handshake
  output logic             READY,
  output logic             BUSY,
  output logic             DONE,
  // results
  output logic [15:0]      RESULT,
  output rsa_flags_t       FLAGS,
  output rsa_flags_t       FLAG_WE,
  output logic             WR_REG,
  output logic             WR_MEM,
  output logic [23:0]      MEM_ADDR,
  output logic [2:0]       INSTR_LEN,
  output logic [15:0]      PTR_NEXT,
  output logic             PTR_WE,
  output logic [9:0]       BIT_ADDR,
  output logic             BIT_SET
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } rsa_state_t;

  rsa_state_t  state;
  logic [3:0]  cnt;
  logic [3:0]  cur_clk;
  logic [3:0]  elapsed;
  logic        wr_reg_q;
  logic        wr_mem_q;
  logic        ptr_we_q;
  logic        bit_set_q;
  rsa_flags_t  we_q;
  rsa_op_t     op_q;
  logic [3:0]  count_q;

  logic        start_ok;
  logic        wide;
  logic [3:0]  rcount;
  rsa_mode_t   mode;
  logic        mem_dest;
  logic [15:0] next_result;
  rsa_flags_t  next_flags;
  rsa_flags_t  next_we;
  logic [3:0]  next_clk;
  logic [2:0]  next_len;
  logic        next_wr_reg;
  logic        next_wr_mem;
  logic [23:0] next_addr;
  logic [15:0] next_ptr;
  logic        next_ptr_we;
  logic [16:0] rot;
  logic [15:0] mask;

  function automatic logic [16:0] rot_f(
    input logic [15:0] v_in,
    input logic        c_in,
    input logic [3:0]  n,
    input logic        w,
    input logic        left,
    input logic        thru
  );
    logic [15:0] v;
    logic        c;
    logic        nb;
    v = v_in;
    c = c_in;
    nb = 1'b0;
    for (int i = 0; i < 15; i++)
    begin
      if (4'(i) < n)
      begin
        if (left)
        begin
          nb = thru ? c : (w ? v[15] : v[7]);
          if (thru)
            c = w ? v[15] : v[7];
          v = {v[14:0], nb};
        end
        else
        begin
          nb = thru ? c : v[0];
          if (thru)
            c = v[0];
          v = {1'b0, v[15:1]};
          if (w)
            v[15] = nb;
          else
            v[7] = nb;
        end
        if (!w)
          v[15:8] = 8'h00;
      end
    end
    return {c, v};
  endfunction : rot_f

  assign wide     = INSTR.b1[WIDTH_BIT_POS];
  assign rcount   = INSTR.b2[3:0];
  assign mode     = rsa_mode_t'(INSTR.b1[2:0]);
  assign mem_dest = INSTR.b2[DIR_BIT_POS];
  assign mask     = wide ? 16'hFFFF : 16'h00FF;
  assign start_ok = START && (state == ST_IDLE);

  assign rot = rot_f(DEST_VAL & mask, FLAG_C, rcount, wide,
                     (OP == OP_ROTL) || (OP == OP_ROTLC),
                     (OP == OP_ROTLC) || (OP == OP_ROTRC));

  always_comb
  begin
    logic [15:0] a;
    logic [15:0] b;
    logic [16:0] d;
    logic [15:0] seg_base;
    logic [23:0] off;
    a           = 16'h0000;
    b           = 16'h0000;
    d           = 17'h00000;
    seg_base    = PTR_VAL;
    off         = 24'h000000;
    next_result = RESULT_RST;
    next_flags  = '0;
    next_we     = '0;
    next_clk    = CLK_REG;
    next_len    = LEN_2;
    next_wr_reg = 1'b0;
    next_wr_mem = 1'b0;
    next_addr   = 24'h000000;
    next_ptr    = PTR_VAL;
    next_ptr_we = 1'b0;
    case (OP)
      OP_ROTL, OP_ROTR, OP_ROTLC, OP_ROTRC:
      begin
        next_result  = rot[15:0];
        next_flags.c = rot[16];
        next_flags.n = wide ? rot[15] : rot[7];
        next_flags.z = (rot[15:0] == 16'h0000);
        next_we.n    = 1'b1;
        next_we.z    = 1'b1;
        next_we.c    = (OP == OP_ROTLC) || (OP == OP_ROTRC);
        next_clk     = CLK_ROT_BASE + {1'b0, rcount[3:1]};
        next_len     = LEN_2;
        next_wr_reg  = 1'b1;
      end
      OP_BSET:
      begin
        next_clk = CLK_BSET;
        next_len = LEN_3;
      end
      OP_SFILL:
      begin
        next_result = FLAG_N ? mask : 16'h0000;
        next_clk    = CLK_SFILL;
        next_len    = LEN_2;
        next_wr_reg = 1'b1;
      end
      OP_MINUS:
      begin
        if (mode == AM_REG || !mem_dest)
          a = DEST_VAL & mask;
        else
          a = MEM_VAL & mask;
        if (mode == AM_REG || mem_dest)
          b = SRC_VAL & mask;
        else
          b = MEM_VAL & mask;
        d = {1'b0, a} - {1'b0, b};
        next_result   = d[15:0] & mask;
        next_flags.c  = wide ? d[16] : (a[7:0] < b[7:0]);
        next_flags.ac = a[3:0] < b[3:0];
        next_flags.n  = wide ? d[15] : d[7];
        next_flags.z  = (next_result == 16'h0000);
        next_flags.v  = wide
                      ? ((a[15] != b[15]) && (d[15] != a[15]))
                      : ((a[7] != b[7]) && (d[7] != a[7]));
        next_we       = '1;
        next_wr_reg   = (mode == AM_REG) || !mem_dest;
        next_wr_mem   = (mode != AM_REG) && mem_dest;
        case (mode)
          AM_REG:
          begin
            next_clk = CLK_REG;
            next_len = LEN_2;
          end
          AM_IND:
          begin
            next_clk = CLK_IND;
            next_len = LEN_2;
          end
          AM_POSTI:
          begin
            next_clk    = CLK_POSTI;
            next_len    = LEN_2;
            next_ptr    = PTR_VAL + (wide ? 16'h0002 : 16'h0001);
            next_ptr_we = 1'b1;
          end
          AM_OFF8:
          begin
            off      = {{16{INSTR.b3[7]}}, INSTR.b3};
            next_clk = CLK_OFF;
            next_len = LEN_3;
          end
          AM_OFF16:
          begin
            off      = {8'h00, INSTR.b3, INSTR.b4};
            next_clk = CLK_OFF;
            next_len = LEN_4;
          end
          AM_DIRECT:
          begin
            next_clk = CLK_DIRECT;
            next_len = LEN_3;
          end
          default:
          begin
            next_wr_reg = 1'b0;
            next_wr_mem = 1'b0;
            next_we     = '0;
          end
        endcase
        next_addr = {SEG_VAL, seg_base} + off;
        if (mode == AM_DIRECT)
          next_addr = {13'h0, INSTR.b2[2:0], INSTR.b3};
      end
      default:
      begin
        next_clk = CLK_REG;
      end
    endcase
  end

  // sequencer
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end
    else if (start_ok)
    begin
      state <= ST_RUN;
      cnt   <= next_clk;
    end
    else if (state == ST_RUN)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1)
        state <= ST_IDLE;
    end
  end

  // latched results
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      RESULT    <= RESULT_RST;
      FLAGS     <= '0;
      we_q      <= '0;
      cur_clk   <= 4'h0;
      INSTR_LEN <= 3'h0;
      wr_reg_q  <= 1'b0;
      wr_mem_q  <= 1'b0;
      MEM_ADDR  <= 24'h000000;
      PTR_NEXT  <= 16'h0000;
      ptr_we_q  <= 1'b0;
      bit_set_q <= 1'b0;
      BIT_ADDR  <= 10'h000;
      op_q      <= OP_ROTL;
      count_q   <= 4'h0;
    end
    else if (start_ok)
    begin
      RESULT    <= next_result;
      FLAGS     <= next_flags;
      we_q      <= next_we;
      cur_clk   <= next_clk;
      INSTR_LEN <= next_len;
      wr_reg_q  <= next_wr_reg;
      wr_mem_q  <= next_wr_mem;
      MEM_ADDR  <= next_addr;
      PTR_NEXT  <= next_ptr;
      ptr_we_q  <= next_ptr_we;
      bit_set_q <= (OP == OP_BSET);
      BIT_ADDR  <= {INSTR.b2[1:0], INSTR.b3};
      op_q      <= OP;
      count_q   <= rcount;
    end
  end

  assign READY   = (state == ST_IDLE);
  assign BUSY    = (state == ST_RUN);
  assign DONE    = BUSY && (cnt == 4'h1);
  assign WR_REG  = DONE && wr_reg_q;
  assign WR_MEM  = DONE && wr_mem_q;
  assign PTR_WE  = DONE && ptr_we_q;
  assign BIT_SET = DONE && bit_set_q;
  assign FLAG_WE = DONE ? we_q : '0;

  // cycles since the accepted request
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      elapsed <= 4'h0;
    else if (start_ok)
      elapsed <= 4'h1;
    else if (BUSY && !DONE)
      elapsed <= elapsed + 4'h1;
  end

  property p_rot_time;
    @(posedge CLK_SYS) disable iff (RST)
    DONE && (op_q inside {OP_ROTL, OP_ROTLC, OP_ROTR, OP_ROTRC})
      |-> elapsed == CLK_ROT_BASE + {1'b0, count_q[3:1]};
  endproperty
  a_rot_time: assert property (p_rot_time)
    else $error("rotate clock count wrong");

  property p_rotl_flags;
    @(posedge CLK_SYS) disable iff (RST)
    DONE && (op_q == OP_ROTL) |-> FLAG_WE == 5'b00011 && WR_REG;
  endproperty
  a_rotl_flags: assert property (p_rotl_flags)
    else $error("rotate left touches wrong flags");

  property p_rotc_flags;
    @(posedge CLK_SYS) disable iff (RST)
    DONE && (op_q == OP_ROTRC) |-> FLAG_WE == 5'b10011;
  endproperty
  a_rotc_flags: assert property (p_rotc_flags)
    else $error("rotate right via carry flag mask wrong");

  property p_zero_count;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && (OP inside {OP_ROTL, OP_ROTR}) && rcount == 4'h0
      |=> RESULT == ($past(DEST_VAL) & $past(mask));
  endproperty
  a_zero_count: assert property (p_zero_count)
    else $error("zero count changed the operand");

  property p_bset_time;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && OP == OP_BSET |-> ##4 (BIT_SET && FLAG_WE == 5'b00000);
  endproperty
  a_bset_time: assert property (p_bset_time)
    else $error("bit set not done in four clocks");

  property p_sfill;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && OP == OP_SFILL && FLAG_N && wide
      |=> RESULT == 16'hFFFF ##2 (WR_REG && FLAG_WE == 5'b00000);
  endproperty
  a_sfill: assert property (p_sfill)
    else $error("sign fill result or timing wrong");

  property p_minus_reg;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && OP == OP_MINUS && mode == AM_REG && wide
      |=> RESULT == 16'($past(DEST_VAL) - $past(SRC_VAL)) ##2 DONE;
  endproperty
  a_minus_reg: assert property (p_minus_reg)
    else $error("register subtract wrong");

  property p_ind_time;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && OP == OP_MINUS && mode == AM_IND
      |-> ##4 (DONE && INSTR_LEN == 3'h2);
  endproperty
  a_ind_time: assert property (p_ind_time)
    else $error("indirect subtract not four clocks");

  property p_off_time;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && OP == OP_MINUS && mode == AM_OFF8
      |-> !DONE [*6] ##1 DONE;
  endproperty
  a_off_time: assert property (p_off_time)
    else $error("offset subtract not six clocks");

  property p_posti;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && OP == OP_MINUS && mode == AM_POSTI && !wide
      |=> PTR_NEXT == $past(PTR_VAL) + 16'h0001 ##4 PTR_WE;
  endproperty
  a_posti: assert property (p_posti)
    else $error("post increment pointer wrong");

  property p_direct;
    @(posedge CLK_SYS) disable iff (RST)
    start_ok && OP == OP_MINUS && mode == AM_DIRECT
      |=> MEM_ADDR[10:0] == {$past(INSTR.b2[2:0]), $past(INSTR.b3)}
          && INSTR_LEN == 3'h3;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct address wrong");

endmodule : rsa_alu

// ==== core/rsa_pkg.sv ====
package rsa_pkg;

  typedef enum logic [2:0] {
    OP_ROTL  = 3'h0,
    OP_ROTLC = 3'h1,
    OP_ROTR  = 3'h2,
    OP_ROTRC = 3'h3,
    OP_BSET  = 3'h4,
    OP_SFILL = 3'h5,
    OP_MINUS = 3'h6
  } rsa_op_t;

  typedef enum logic [2:0] {
    AM_REG    = 3'h1,
    AM_IND    = 3'h2,
    AM_POSTI  = 3'h3,
    AM_OFF8   = 3'h4,
    AM_OFF16  = 3'h5,
    AM_DIRECT = 3'h6
  } rsa_mode_t;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } rsa_instr_t;

  typedef struct packed {
    logic c;
    logic ac;
    logic v;
    logic n;
    logic z;
  } rsa_flags_t;

  localparam int        WIDTH_BIT_POS = 3;
  localparam int        DIR_BIT_POS   = 3;
  localparam logic [3:0] CLK_ROT_BASE = 4'h4;
  localparam logic [3:0] CLK_BSET     = 4'h4;
  localparam logic [3:0] CLK_SFILL    = 4'h3;
  localparam logic [3:0] CLK_REG      = 4'h3;
  localparam logic [3:0] CLK_IND      = 4'h4;
  localparam logic [3:0] CLK_POSTI    = 4'h5;
  localparam logic [3:0] CLK_OFF      = 4'h6;
  localparam logic [3:0] CLK_DIRECT   = 4'h4;
  localparam logic [2:0] LEN_2        = 3'h2;
  localparam logic [2:0] LEN_3        = 3'h3;
  localparam logic [2:0] LEN_4        = 3'h4;
  localparam logic [15:0] RESULT_RST  = 16'h0000;

endpackage : rsa_pkg

// ==== tb/rsa_alu_test.sv ====
`timescale 1ns/1ns
module rsa_alu_test;
  import rsa_pkg::*;

  localparam int LIMIT = 4000;
  localparam logic [15:0] DV = 16'h3A05;
  localparam logic [15:0] SV = 16'h1238;
  localparam logic [15:0] MV = 16'h8017;

  logic        clk_sys;
  logic        rst;
  logic        start;
  rsa_op_t     op_in;
  rsa_instr_t  instr;
  logic [15:0] dest_val;
  logic [15:0] src_val;
  logic [15:0] mem_val;
  logic [15:0] ptr_val;
  logic [7:0]  seg_val;
  logic        flag_c;
  logic        flag_n;
  logic        ready;
  logic        busy;
  logic        done;
  logic [15:0] result;
  rsa_flags_t  flags;
  rsa_flags_t  flag_we;
  logic        wr_reg;
  logic        wr_mem;
  logic [23:0] mem_addr;
  logic [2:0]  instr_len;
  logic [15:0] ptr_next;
  logic        ptr_we;
  logic [9:0]  bit_addr;
  logic        bit_set;
  int          err_total;
  int          check_count;
  int          cycles = 0;
  int          clk_tab [7] = '{0, 3, 4, 5, 6, 6, 4};
  int          len_tab [7] = '{0, 2, 2, 2, 3, 4, 3};
  int          cnts [4] = '{0, 1, 7, 15};

  rsa_alu uut (
    .CLK_SYS(clk_sys), .RST(rst), .START(start), .OP(op_in),
    .INSTR(instr), .DEST_VAL(dest_val), .SRC_VAL(src_val),
    .MEM_VAL(mem_val), .PTR_VAL(ptr_val), .SEG_VAL(seg_val),
    .FLAG_C(flag_c), .FLAG_N(flag_n), .READY(ready), .BUSY(busy),
    .DONE(done), .RESULT(result), .FLAGS(flags), .FLAG_WE(flag_we),
    .WR_REG(wr_reg), .WR_MEM(wr_mem), .MEM_ADDR(mem_addr),
    .INSTR_LEN(instr_len), .PTR_NEXT(ptr_next), .PTR_WE(ptr_we),
    .BIT_ADDR(bit_addr), .BIT_SET(bit_set)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  task automatic check_val(input string nm, input logic [23:0] e,
                           input logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : check_val

  // one instruction: launch, wait for done, check clocks and length
  task automatic exec(input rsa_op_t op, input rsa_instr_t ins,
                      input logic [15:0] d, input logic [15:0] m,
                      input int eclk, input int elen);
    int n;
    @(negedge clk_sys);
    op_in = op;
    instr = ins;
    dest_val = d;
    mem_val = m;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    check_val("busy", 24'h1, {22'h0, ready, busy});
    n = 1;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    check_val("clocks", eclk[23:0], n[23:0]);
    check_val("length", elen[23:0], {21'h0, instr_len});
  endtask : exec

  function automatic logic [16:0] rot_model(
    input logic [15:0] v, input logic c, input int n,
    input logic w, input logic left, input logic thru);
    logic        msb;
    logic        lsb;
    logic [15:0] r;
    r = w ? v : {8'h00, v[7:0]};
    for (int i = 0; i < n; i++)
    begin
      msb = w ? r[15] : r[7];
      lsb = r[0];
      if (left)
        r = {r[14:0], thru ? c : msb};
      else
      begin
        r = r >> 1;
        if (w)
          r[15] = thru ? c : lsb;
        else
          r[7] = thru ? c : lsb;
      end
      if (thru)
        c = left ? msb : lsb;
      if (!w)
        r[15:8] = 8'h00;
    end
    return {c, r};
  endfunction : rot_model

  function automatic logic [20:0] sub_model(
    input logic [15:0] a, input logic [15:0] b, input logic w);
    logic [16:0] d;
    logic [4:0]  hb;
    logic        v;
    d = w ? {1'b0, a} - {1'b0, b} : {9'h0, a[7:0]} - {9'h0, b[7:0]};
    hb = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    v = w ? (a[15] ^ b[15]) & (d[15] ^ a[15])
          : (a[7] ^ b[7]) & (d[7] ^ a[7]);
    return {w ? d[16] : d[8], hb[4], v, w ? d[15] : d[7],
            w ? d[15:0] == 16'h0000 : d[7:0] == 8'h00,
            w ? d[15:0] : {8'h00, d[7:0]}};
  endfunction : sub_model

  initial
  begin
    logic [16:0] re;
    logic [20:0] se;
    logic [4:0]  m;
    logic [3:0]  cnt;
    logic [7:0]  b3;
    logic [23:0] ea;
    logic        md;
    err_total = 0;
    check_count = 0;
    rst = 1'b1;
    start = 1'b0;
    op_in = OP_ROTL;
    instr = 32'h0000_0000;
    dest_val = 16'h0000;
    src_val = SV;
    mem_val = 16'h0000;
    ptr_val = 16'hFFFE;
    seg_val = 8'h3C;
    flag_c = 1'b1;
    flag_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    check_val("idle ready", 24'h1, {23'h0, ready});
    check_val("idle result", 24'h0, {8'h0, result});
    // rotates over every op, width and edge counts
    for (int o = 0; o < 4; o++)
      for (int w = 0; w < 2; w++)
        for (int k = 0; k < 4; k++)
        begin
          cnt = cnts[k][3:0];
          re = rot_model(16'hA5C3, 1'b1, cnts[k], w[0], o < 2, o[0]);
          m = o[0] ? 5'h13 : 5'h03;
          exec(rsa_op_t'(o), {4'h0, w[0], 3'h0, 4'h0, cnt, 16'h0},
               16'hA5C3, 16'h0, 4 + cnts[k] / 2, 2);
          check_val("rot result", re[15:0],
                    result);
          check_val("rot wr", 24'h1, {22'h0, wr_mem, wr_reg});
          check_val("rot we", m, flag_we);
          check_val("rot flags", {re[16], 2'b00,
                    w ? re[15] : re[7],
                    w ? re[15:0] == 16'h0 : re[7:0] == 8'h0} & m,
                    flags & m);
        end
    exec(OP_BSET, 32'h0002_5A00, DV, MV, 4, 3);
    check_val("bit addr", 24'h25A, bit_addr);
    check_val("bit set", 24'h1, {23'h0, bit_set});
    check_val("bit we", 24'h0, flag_we);
    for (int w = 0; w < 2; w++)
      for (int f = 0; f < 2; f++)
      begin
        flag_n = f[0];
        exec(OP_SFILL, {4'h9, w[0], 3'h0, 8'h19, 16'h0}, DV, MV,
             3, 2);
        check_val("fill", f ? (w ? 16'hFFFF : 16'h00FF) : 16'h0,
                  result);
        check_val("fill we", 24'h0, flag_we);
      end
    // subtract in every addressing form, both widths and directions
    for (int a = 1; a < 7; a++)
      for (int w = 0; w < 2; w++)
        for (int t = 0; t < 2; t++)
        begin
          md = (a != 1) && t[0];
          b3 = (a == 4) ? 8'hF0 : ((a == 5) ? 8'h01 : 8'hA7);
          se = sub_model(md ? MV : DV, (md || a == 1) ? SV : MV, w[0]);
          m = 5'h1F;
          exec(OP_MINUS, {4'h2, w[0], a[2:0], 4'h2, t[0], 3'h5, b3,
               8'h34}, DV, MV, clk_tab[a],
               len_tab[a]);
          check_val("sub result", se[15:0], result);
          check_val("sub flags", se[20:16] & m, flags & m);
          check_val("sub we", 24'h1F, flag_we);
          check_val("sub wr", {md, !md}, {wr_mem, wr_reg});
          ea = {8'h3C, 16'hFFFE};
          if (a == 4)
            ea = ea + 24'hFFFFF0;
          if (a == 5)
            ea = ea + 24'h000134;
          if (a == 6)
            ea = 24'h0005A7;
          if (a > 1)
            check_val("address", ea,
                      mem_addr);
          if (a == 3)
            check_val("ptr", {w ? 16'h0000 : 16'hFFFF, 1'b1},
                      {ptr_next, ptr_we});
        end
    print_verdict();
  end

endmodule : rsa_alu_test
